// [rtl/cal_sequencer.sv]
// Calibration sequencer: turns a launch request into start pulse and busy level
// Assumes cal_complete comes from the VCO calibration engine, synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module cal_sequencer
  import pll2_cal_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic launch,
  input wire logic cal_complete,
  // Status
  output logic cal_start,
  output logic cal_busy
);
  typedef struct packed {
    cal_state_e state;
    logic start;
  } seq_s;

  seq_s cur;
  seq_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.start = 1'b0;
    unique case (cur.state)
      cal_idle: begin
        if (launch) begin
          next_cur.state = cal_running;
          next_cur.start = 1'b1;
        end
      end
      cal_running: begin
        // A new launch restarts the routine
        if (launch) begin
          next_cur.start = 1'b1;
        end else if (cal_complete) begin
          next_cur.state = cal_idle;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{state: cal_idle, start: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign cal_start = cur.start;
  assign cal_busy = (cur.state == cal_running);

  a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    cal_start |-> cal_busy)
    else $error("start pulse without busy");
endmodule // cal_sequencer
`default_nettype wire

// [rtl/pll2_cal_map.svh]
// Register indices, field positions and reset values of the PLL2 divider bank
// Assumes APB byte address = register index times four
`ifndef PLL2_CAL_MAP_SVH
`define PLL2_CAL_MAP_SVH

// Register indices
`define IDX_OPTIONS 10'h162
`define IDX_CAL_HIGH 10'h163
`define IDX_CAL_MID 10'h164
`define IDX_CAL_LOW 10'h165
`define IDX_DIS_HIGH 10'h166
`define IDX_FB_MID 10'h167
`define IDX_FB_LOW 10'h168
`define IDX_STATUS 10'h170

// Field positions
`define PRESC_MSB 7
`define PRESC_LSB 5
`define RANGE_MSB 4
`define RANGE_LSB 2
`define XTAL_BIT 1
`define DBL_BIT 0
`define FCAL_DIS_BIT 2
`define DIV_HIGH_MSB 1

// Reset values
`define RST_OPTIONS 8'h5d
`define RST_DIV_HIGH 2'h0
`define RST_DIV_MID 8'h00
`define RST_DIV_LOW 8'h0c
`define RST_FCAL_DIS 1'h0

// Prescaler and reference range codes
`define PRESC_CODE_DIV8 3'h0
`define PRESC_CODE_DIV2A 3'h1
`define PRESC_CODE_DIV2B 3'h2
`define PRESC_RATIO_8 4'h8
`define PRESC_RATIO_2 4'h2
`define RANGE_TO_63M 3'h0
`define RANGE_TO_127M 3'h1
`define RANGE_TO_255M 3'h2
`define RANGE_TO_500M 3'h4

// Cascaded zero-delay feedback select code
`define FB_SEL_CASCADED 2'h1

// Status bits
`define ST_BUSY_BIT 0
`define ST_CASCADED_BIT 1
`define ST_RANGE_BAD_BIT 2
`define ST_N_BAD_BIT 3
`define ST_NCAL_BAD_BIT 4

`endif

// [rtl/pll2_cal_pkg.sv]
// Types shared by the PLL2 divider bank and its calibration sequencer
// Assumes the map header is included by the users
package pll2_cal_pkg;
  typedef logic [17:0] divider_t;
  typedef enum logic {cal_idle, cal_running} cal_state_e;
endpackage

// [rtl/pll2_divider_calibration_regs.sv]
// PLL2 prescaler, reference options and feedback divider registers on APB
// Assumes an APB master on pclk; calibration engine reports completion
//
// What this block does
// - Prescaler code 0 divides by 8, 1 and 2 by 2, 3..7 by code.
// - Range codes 0,1,2,4 select bands up to 500 MHz; others reserved.
// - Crystal amplifier enable bit turns the oscillator amplifier off or on.
// - Doubler enable bit bypasses or inserts the reference doubler.
// - Zero-delay configuration is never active during calibration.
// - Cascaded mode calibrates with calibration divider, then uses normal divider.
// - Cascaded zero-delay mode holds exactly when feedback select equals 1.
// - Calibration divider is 18 bits over three registers; zero invalid.
// - Normal divider is 18 bits over three registers; zero invalid.
// - Writing normal divider low byte launches calibration when enabled.
// - Calibration-disable bit suppresses the launch on a low-byte write.
`timescale 1ns/1ns
`default_nettype none
`include "pll2_cal_map.svh"
module pll2_divider_calibration_regs
  import pll2_cal_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Feedback path select and calibration engine
  input wire logic [1:0] feedback_clock_select,
  input wire logic cal_complete,
  // PLL2 controls
  output logic [3:0] vco_feedback_prescaler,
  output logic [2:0] reference_range_code,
  output logic reference_range_reserved,
  output logic crystal_amp_enable,
  output logic reference_doubler_enable,
  output logic [17:0] active_feedback_divider,
  output logic main_divider_invalid,
  output logic cal_divider_invalid,
  output logic cascaded_zero_delay,
  output logic zero_delay_active,
  output logic cal_start,
  output logic cal_busy
);
  typedef struct packed {
    logic [7:0] options;
    logic [1:0] cal_high;
    logic [7:0] cal_mid;
    logic [7:0] cal_low;
    logic fcal_dis;
    logic [1:0] fb_high;
    logic [7:0] fb_mid;
    logic [7:0] fb_low;
    logic [7:0] rdata;
    logic miss;
  } regs_s;

  regs_s cur;
  regs_s next_cur;
  logic [9:0] index;
  logic setup;
  logic wr_en;
  logic launch;
  divider_t main_feedback_divider;
  divider_t calibration_feedback_divider;
  logic [7:0] status;

  function automatic logic [3:0] prescale_ratio(input logic [2:0] code);
    if (code == `PRESC_CODE_DIV8) begin
      prescale_ratio = `PRESC_RATIO_8;
    end else if (code == `PRESC_CODE_DIV2A || code == `PRESC_CODE_DIV2B) begin
      prescale_ratio = `PRESC_RATIO_2;
    end else begin
      prescale_ratio = {1'b0, code};
    end
  endfunction

  function automatic logic range_is_reserved(input logic [2:0] code);
    range_is_reserved = !(code == `RANGE_TO_63M || code == `RANGE_TO_127M ||
                          code == `RANGE_TO_255M || code == `RANGE_TO_500M);
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx >= `IDX_OPTIONS && idx <= `IDX_FB_LOW) || idx == `IDX_STATUS;
  endfunction

  assign index = paddr[11:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0] && is_mapped(index);

  // Dividers assembled from their byte registers
  assign calibration_feedback_divider = {cur.cal_high, cur.cal_mid, cur.cal_low};
  assign main_feedback_divider = {cur.fb_high, cur.fb_mid, cur.fb_low};

  // Low-byte write launches calibration unless disabled
  assign launch = wr_en && index == `IDX_FB_LOW && !cur.fcal_dis;

  always_comb begin
    status = 8'h00;
    status[`ST_BUSY_BIT] = cal_busy;
    status[`ST_CASCADED_BIT] = cascaded_zero_delay;
    status[`ST_RANGE_BAD_BIT] = reference_range_reserved;
    status[`ST_N_BAD_BIT] = main_divider_invalid;
    status[`ST_NCAL_BAD_BIT] = cal_divider_invalid;
  end

  always_comb begin
    next_cur = cur;
    // Read data and decode captured in the setup phase
    if (setup) begin
      next_cur.miss = !is_mapped(index);
      unique case (index)
        `IDX_OPTIONS: next_cur.rdata = cur.options;
        `IDX_CAL_HIGH: next_cur.rdata = {6'h00, cur.cal_high};
        `IDX_CAL_MID: next_cur.rdata = cur.cal_mid;
        `IDX_CAL_LOW: next_cur.rdata = cur.cal_low;
        `IDX_DIS_HIGH: next_cur.rdata = {5'h00, cur.fcal_dis, cur.fb_high};
        `IDX_FB_MID: next_cur.rdata = cur.fb_mid;
        `IDX_FB_LOW: next_cur.rdata = cur.fb_low;
        `IDX_STATUS: next_cur.rdata = status;
        default: next_cur.rdata = 8'h00;
      endcase
    end
    if (wr_en) begin
      unique case (index)
        `IDX_OPTIONS: next_cur.options = pwdata[7:0];
        `IDX_CAL_HIGH: next_cur.cal_high = pwdata[`DIV_HIGH_MSB:0];
        `IDX_CAL_MID: next_cur.cal_mid = pwdata[7:0];
        `IDX_CAL_LOW: next_cur.cal_low = pwdata[7:0];
        `IDX_DIS_HIGH: begin
          next_cur.fcal_dis = pwdata[`FCAL_DIS_BIT];
          next_cur.fb_high = pwdata[`DIV_HIGH_MSB:0];
        end
        `IDX_FB_MID: next_cur.fb_mid = pwdata[7:0];
        `IDX_FB_LOW: next_cur.fb_low = pwdata[7:0];
        default: next_cur.options = cur.options;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{options: `RST_OPTIONS,
               cal_high: `RST_DIV_HIGH,
               cal_mid: `RST_DIV_MID,
               cal_low: `RST_DIV_LOW,
               fcal_dis: `RST_FCAL_DIS,
               fb_high: `RST_DIV_HIGH,
               fb_mid: `RST_DIV_MID,
               fb_low: `RST_DIV_LOW,
               rdata: 8'h00,
               miss: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // APB answer: zero wait states, error on unmapped index
  assign pready = 1'b1;
  assign pslverr = psel && penable && cur.miss;
  assign prdata = {24'h00_0000, cur.rdata};

  cal_sequencer u_cal_sequencer (
    .pclk(pclk),
    .presetn(presetn),
    .launch(launch),
    .cal_complete(cal_complete),
    .cal_start(cal_start),
    .cal_busy(cal_busy)
  );

  // Option decode
  assign vco_feedback_prescaler = prescale_ratio(cur.options[`PRESC_MSB:`PRESC_LSB]);
  assign reference_range_code = cur.options[`RANGE_MSB:`RANGE_LSB];
  assign reference_range_reserved = range_is_reserved(reference_range_code);
  assign crystal_amp_enable = cur.options[`XTAL_BIT];
  assign reference_doubler_enable = cur.options[`DBL_BIT];

  // Feedback path and divider selection
  assign cascaded_zero_delay = (feedback_clock_select == `FB_SEL_CASCADED);
  assign zero_delay_active = (feedback_clock_select != 2'h0) && !cal_busy;
  assign active_feedback_divider = (cal_busy && cascaded_zero_delay) ?
    calibration_feedback_divider : main_feedback_divider;
  assign main_divider_invalid = (main_feedback_divider == 18'h0_0000);
  assign cal_divider_invalid = (calibration_feedback_divider == 18'h0_0000);

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence low_byte_write;
    psel && penable && pwrite && pstrb[0] && index == `IDX_FB_LOW;
  endsequence

  sequence start_pulse;
    cal_start ##1 cal_busy;
  endsequence

  a_prescale_div8: assert property (
    cur.options[`PRESC_MSB:`PRESC_LSB] == 3'h0 |-> vco_feedback_prescaler == 4'h8)
    else $error("prescaler code 0 not divide by 8");
  a_prescale_code: assert property (
    cur.options[`PRESC_MSB:`PRESC_LSB] >= 3'h3 |->
      vco_feedback_prescaler == {1'b0, cur.options[`PRESC_MSB:`PRESC_LSB]}
      && vco_feedback_prescaler >= 4'h3)
    else $error("prescaler ratio differs from code");
  a_range_reserved: assert property (
    reference_range_reserved == (reference_range_code inside {3'h3, 3'h5, 3'h6, 3'h7}))
    else $error("reserved range flag wrong");
  a_xtal_enable: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_OPTIONS |=>
      crystal_amp_enable == $past(pwdata[`XTAL_BIT]))
    else $error("crystal enable not written");
  a_doubler_enable: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_OPTIONS |=>
      reference_doubler_enable == $past(pwdata[`DBL_BIT]))
    else $error("doubler enable not written");
  a_no_zero_delay: assert property (
    cal_busy |-> !zero_delay_active)
    else $error("zero delay during calibration");
  a_cal_divider_use: assert property (
    cal_busy && cascaded_zero_delay |->
      active_feedback_divider == {cur.cal_high, cur.cal_mid, cur.cal_low})
    else $error("calibration divider not used");
  a_normal_after_cal: assert property (
    cal_busy && cal_complete && !launch |=> active_feedback_divider == main_feedback_divider)
    else $error("normal divider not restored");
  a_cascade_select: assert property (
    cascaded_zero_delay == (feedback_clock_select == 2'h1))
    else $error("cascaded mode decode wrong");
  a_cal_div_zero: assert property (
    {cur.cal_high, cur.cal_mid, cur.cal_low} == 18'h0_0000 |-> cal_divider_invalid)
    else $error("zero calibration divider not flagged");
  a_main_div_zero: assert property (
    main_divider_invalid == ({cur.fb_high, cur.fb_mid, cur.fb_low} == 18'h0_0000))
    else $error("zero main divider flag wrong");
  a_launch_cal: assert property (
    low_byte_write and !cur.fcal_dis |=> start_pulse)
    else $error("low byte write did not launch");
  a_cal_disabled: assert property (
    cur.fcal_dis && !cal_busy && !cal_start |=> !cal_start)
    else $error("calibration launched while disabled");
  a_prescale_div2: assert property (
    cur.options[`PRESC_MSB:`PRESC_LSB] inside {`PRESC_CODE_DIV2A, `PRESC_CODE_DIV2B} |->
      vco_feedback_prescaler == `PRESC_RATIO_2)
    else $error("prescaler code 1 or 2 not divide by 2");
  a_range_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_OPTIONS |=>
      reference_range_code == $past(pwdata[`RANGE_MSB:`RANGE_LSB]))
    else $error("reference range code not written");
  a_zero_delay_idle: assert property (
    !cal_busy && feedback_clock_select != 2'h0 |-> zero_delay_active)
    else $error("zero delay path not active while idle");
  a_main_div_idle: assert property (
    !cal_busy |-> active_feedback_divider == main_feedback_divider)
    else $error("normal divider not used while idle");
  a_main_div_direct: assert property (
    cal_busy && !cascaded_zero_delay |-> active_feedback_divider == main_feedback_divider)
    else $error("calibration divider used outside cascaded mode");
  a_busy_holds: assert property (
    cal_busy && !cal_complete |=> cal_busy)
    else $error("calibration ended without completion");
  a_cal_high_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_CAL_HIGH |=>
      cur.cal_high == $past(pwdata[`DIV_HIGH_MSB:0]))
    else $error("calibration divider high bits not written");
  a_cal_mid_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_CAL_MID |=>
      cur.cal_mid == $past(pwdata[7:0]))
    else $error("calibration divider middle byte not written");
  a_cal_low_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_CAL_LOW |=>
      cur.cal_low == $past(pwdata[7:0]))
    else $error("calibration divider low byte not written");
  a_fb_high_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_DIS_HIGH |=>
      cur.fb_high == $past(pwdata[`DIV_HIGH_MSB:0]))
    else $error("normal divider high bits not written");
  a_fb_mid_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_FB_MID |=>
      cur.fb_mid == $past(pwdata[7:0]))
    else $error("normal divider middle byte not written");
  a_fb_low_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_FB_LOW |=>
      cur.fb_low == $past(pwdata[7:0]))
    else $error("normal divider low byte not written");
  a_start_single: assert property (
    cal_start && !launch |=> !cal_start)
    else $error("start pulse longer than one cycle");
  a_fcal_dis_write: assert property (
    psel && penable && pwrite && pstrb[0] && index == `IDX_DIS_HIGH |=>
      cur.fcal_dis == $past(pwdata[`FCAL_DIS_BIT]))
    else $error("calibration disable bit not written");
  a_disabled_no_start: assert property (
    low_byte_write and cur.fcal_dis && !cal_busy |=> !cal_start && !cal_busy)
    else $error("disabled low byte write started calibration");
endmodule // pll2_divider_calibration_regs
`default_nettype wire

// [tb/pll2_divider_calibration_regs_tb.sv]
// Self-checking bench for the PLL2 divider and calibration register bank
// Assumes the map header is on the include path; bench acts as APB master
`timescale 1ns/1ns
`default_nettype none
`include "pll2_cal_map.svh"
module pll2_divider_calibration_regs_tb;
  import pll2_cal_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, cal_complete;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb, vco_feedback_prescaler;
  logic pready, pslverr, reference_range_reserved, crystal_amp_enable;
  logic reference_doubler_enable, main_divider_invalid, cal_divider_invalid;
  logic cascaded_zero_delay, zero_delay_active, cal_start, cal_busy;
  logic [1:0] feedback_clock_select;
  logic [2:0] reference_range_code, cv;
  logic [17:0] active_feedback_divider, cal, mn;
  logic [32:0] notes[$];
  int fails, comparisons, starts, cycles, s0;

  pll2_divider_calibration_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .feedback_clock_select(feedback_clock_select), .cal_complete(cal_complete),
    .vco_feedback_prescaler(vco_feedback_prescaler),
    .reference_range_code(reference_range_code),
    .reference_range_reserved(reference_range_reserved),
    .crystal_amp_enable(crystal_amp_enable),
    .reference_doubler_enable(reference_doubler_enable),
    .active_feedback_divider(active_feedback_divider),
    .main_divider_invalid(main_divider_invalid), .cal_divider_invalid(cal_divider_invalid),
    .cascaded_zero_delay(cascaded_zero_delay), .zero_delay_active(zero_delay_active),
    .cal_start(cal_start), .cal_busy(cal_busy));

  always #10 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; the note is the expected {pslverr, read data}
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      input logic [3:0] s, input logic [32:0] note);
    notes.push_back(note);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 4'hf, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00, 4'hf, {25'h000_0000, e});
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // Result watcher: takes the oldest note at each completed transfer
  always @(posedge pclk) begin
    cycles++;
    if (cal_start === 1'b1) starts++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("[ERR] apb note expected present seen empty");
      end else begin
        chk("apb response", {pslverr, pwrite ? 32'h0 : prdata}, notes.pop_front());
      end
    end
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cal_complete} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    feedback_clock_select = 2'h0;
    rnd = 32'h0001_0f62;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_CAL_HIGH, 8'h00);
    rd(`IDX_CAL_LOW, 8'h0c);
    rd(`IDX_FB_LOW, 8'h0c);
    rd(`IDX_DIS_HIGH, 8'h00);
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      cv = c[2:0];
      wr(`IDX_OPTIONS, {cv, cv, cv[0], cv[1]});
      settle(1);
      chk("ratio", vco_feedback_prescaler, cv == 0 ? 4'h8 : (cv < 3 ? 4'h2 : {1'b0, cv}));
      chk("range", reference_range_code, cv);
      chk("reserved", reference_range_reserved, cv == 3 || cv > 4);
      chk("xtal", crystal_amp_enable, cv[0]);
      chk("doubler", reference_doubler_enable, cv[1]);
    end
    xfer(1'b1, `IDX_OPTIONS, 8'h00, 4'h0, 33'h0_0000_0000);
    rd(`IDX_OPTIONS, 8'hff);
    xfer(1'b0, 10'h16f, 8'h00, 4'hf, 33'h1_0000_0000);
    xfer(1'b1, 10'h16f, 8'h55, 4'hf, 33'h1_0000_0000);
    $display("test options and refusals done");
    rnd = lfsr(rnd);
    cal = rnd[17:0] | 18'h0_0001;
    rnd = lfsr(rnd);
    mn = rnd[17:0] | 18'h0_0001;
    feedback_clock_select <= 2'h1;
    wr(`IDX_CAL_HIGH, {6'h00, cal[17:16]});
    wr(`IDX_CAL_MID, cal[15:8]);
    wr(`IDX_CAL_LOW, cal[7:0]);
    wr(`IDX_DIS_HIGH, {6'h00, mn[17:16]});
    wr(`IDX_FB_MID, mn[15:8]);
    s0 = starts;
    wr(`IDX_FB_LOW, mn[7:0]);
    settle(2);
    chk("cal launches", starts, s0 + 1);
    chk("busy", cal_busy, 1'b1);
    chk("cal divider used", active_feedback_divider, cal);
    chk("zero delay off", zero_delay_active, 1'b0);
    chk("cascaded", cascaded_zero_delay, 1'b1);
    @(posedge pclk);
    cal_complete <= 1'b1;
    @(posedge pclk);
    cal_complete <= 1'b0;
    settle(1);
    chk("busy ends", cal_busy, 1'b0);
    chk("main divider used", active_feedback_divider, mn);
    rd(`IDX_CAL_HIGH, {6'h00, cal[17:16]});
    rd(`IDX_CAL_MID, cal[15:8]);
    rd(`IDX_FB_MID, mn[15:8]);
    rd(`IDX_FB_LOW, mn[7:0]);
    feedback_clock_select <= 2'h2;
    settle(1);
    chk("zero delay on", zero_delay_active, 1'b1);
    chk("not cascaded", cascaded_zero_delay, 1'b0);
    $display("test calibration done");
    @(posedge pclk);
    feedback_clock_select <= 2'h1;
    wr(`IDX_DIS_HIGH, 8'h04);
    wr(`IDX_FB_MID, 8'h00);
    wr(`IDX_CAL_HIGH, 8'h00);
    wr(`IDX_CAL_MID, 8'h00);
    wr(`IDX_CAL_LOW, 8'h00);
    s0 = starts;
    wr(`IDX_FB_LOW, 8'h00);
    settle(2);
    chk("cal suppressed", starts, s0);
    chk("idle", cal_busy, 1'b0);
    chk("main zero", main_divider_invalid, 1'b1);
    chk("cal zero", cal_divider_invalid, 1'b1);
    rd(`IDX_DIS_HIGH, 8'h04);
    rd(`IDX_STATUS, 8'h1e);
    settle(2);
    $display("test disable and zero dividers done");
    finish_test();
  end
endmodule // pll2_divider_calibration_regs_tb
`default_nettype wire
